// ---- include/bridge_cfg_consts.vh ----
`ifndef BRIDGE_CFG_CONSTS_VH
`define BRIDGE_CFG_CONSTS_VH

`define OFF_UPSTREAM_SWITCH_ISSUE_LIMIT 12'h008
`define OFF_BYPASS_MERGE_CTRL 12'h024
`define OFF_LONG_BURST_CTRL 12'h02c
`define OFF_WRITE_FIFO_WATERMARK 12'h040
`define OFF_ISSUE_LIMIT_CTRL 12'h108

`define RST_UPSTREAM_SWITCH_ISSUE_LIMIT 2'h0
`define RST_BYPASS_MERGE_CTRL 1'h0
`define RST_LONG_BURST_CTRL 1'h0
`define RST_ISSUE_LIMIT_CTRL 2'h0

`define BIT_READ_OVERRIDE 0
`define BIT_WRITE_OVERRIDE 1

`define ADDR_W 12

`endif

// ---- verilog/cfg_field.v ----
`timescale 1ns/1ps
// One writable register field with a constant reset value.
module cfg_field #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire pclk,
  input wire presetn,
  input wire we,
  input wire [W-1:0] wdata,
  output reg [W-1:0] q_reg
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= RST;
    end else if (we) begin
      q_reg <= wdata;
    end
  end
endmodule

// ---- verilog/watermark_field.v ----
`timescale 1ns/1ps
// Watermark field. The reset value is the generation-time watermark, which is a
// parameter, so it stays a constant under the asynchronous reset.
module watermark_field #(
  parameter [3:0] WATERMARK_INIT = 4'h0
) (
  input wire pclk,
  input wire presetn,
  input wire we,
  input wire [3:0] wdata,
  output reg [3:0] q_reg
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= WATERMARK_INIT;
    end else if (we) begin
      q_reg <= wdata;
    end
  end
endmodule

// ---- verilog/bridge_block_config_regs.v ----
`timescale 1ns/1ps
`include "bridge_cfg_consts.vh"
module bridge_block_config_regs #(
  parameter HAS_REG_VIEW = 1,
  parameter HAS_WIDTH_CONV = 1,
  parameter HAS_AXI4_DOWNSIZE = 1,
  parameter HAS_WRITE_FIFO = 1,
  parameter [3:0] WATERMARK_INIT = 4'h4,
  parameter HAS_SWITCH_LINK = 1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg bypass_merge_en,
  output reg long_burst_allow,
  output reg long_burst_break,
  output reg [3:0] write_watermark,
  output reg read_issue_one,
  output reg write_issue_one,
  output reg upstream_read_issue_one,
  output reg upstream_write_issue_one
);

  ////////////////////////////////////////////////////////////////////////////
  // Which registers this build has.
  localparam HAVE_LB = (HAS_AXI4_DOWNSIZE != 0) && (HAS_REG_VIEW != 0);
  localparam HAVE_BM = (HAS_WIDTH_CONV != 0);
  localparam HAVE_WM = (HAS_WRITE_FIFO != 0) && (WATERMARK_INIT != 4'h0);
  localparam HAVE_SW = (HAS_SWITCH_LINK != 0);

  // Decode used by both the write strobes and the read mux.
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    input present;
    begin
      hit = present && (a == off);
    end
  endfunction

  wire [`ADDR_W-1:0] addr = paddr[`ADDR_W-1:0];
  wire in_range = (paddr[31:`ADDR_W] == 20'h00000);
  // Single-cycle access phase: pready is registered high on the edge after each setup phase.
  wire wr_en = psel && penable && pwrite && in_range;

  wire hit_sw = hit(addr, `OFF_UPSTREAM_SWITCH_ISSUE_LIMIT, HAVE_SW);
  wire hit_bm = hit(addr, `OFF_BYPASS_MERGE_CTRL, HAVE_BM);
  wire hit_lb = hit(addr, `OFF_LONG_BURST_CTRL, HAVE_LB);
  wire hit_wm = hit(addr, `OFF_WRITE_FIFO_WATERMARK, HAVE_WM);
  wire hit_il = hit(addr, `OFF_ISSUE_LIMIT_CTRL, 1'b1);

  wire [1:0] sw_q;
  wire [0:0] bm_q;
  wire [0:0] lb_q;
  wire [3:0] wm_q;
  wire [1:0] il_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  cfg_field #(
    .W(2),
    .RST(`RST_UPSTREAM_SWITCH_ISSUE_LIMIT)
  ) u_sw (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && hit_sw),
    .wdata(pwdata[1:0]),
    .q_reg(sw_q)
  );
  cfg_field #(
    .W(1),
    .RST(`RST_BYPASS_MERGE_CTRL)
  ) u_bm (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && hit_bm),
    .wdata(pwdata[0:0]),
    .q_reg(bm_q)
  );
  cfg_field #(
    .W(1),
    .RST(`RST_LONG_BURST_CTRL)
  ) u_lb (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && hit_lb),
    .wdata(pwdata[0:0]),
    .q_reg(lb_q)
  );
  watermark_field #(
    .WATERMARK_INIT(WATERMARK_INIT)
  ) u_wm (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && hit_wm),
    .wdata(pwdata[3:0]),
    .q_reg(wm_q)
  );
  cfg_field #(
    .W(2),
    .RST(`RST_ISSUE_LIMIT_CTRL)
  ) u_il (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && hit_il),
    .wdata(pwdata[1:0]),
    .q_reg(il_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux. Anything not decoded returns zero and writes there are dropped.
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h00000000;
    if (in_range) begin
      if (hit_sw) begin
        rdata_next = {30'h00000000, sw_q};
      end else if (hit_bm) begin
        rdata_next = {31'h00000000, bm_q};
      end else if (hit_lb) begin
        rdata_next = {31'h00000000, lb_q};
      end else if (hit_wm) begin
        rdata_next = {28'h0000000, wm_q};
      end else if (hit_il) begin
        rdata_next = {30'h00000000, il_q};
      end
    end
  end

  // Effective controls. An absent register drives zero, and an
  // absent long-burst register always forces burst breaking.
  wire lb_eff = HAVE_LB ? lb_q[0] : 1'b0;
  wire bm_eff = HAVE_BM ? bm_q[0] : 1'b0;
  wire [3:0] wm_eff = HAVE_WM ? wm_q : 4'h0;
  wire [1:0] sw_eff = HAVE_SW ? sw_q : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and control outputs, all registered. The answer lands one edge
  // after setup, so the access phase is always exactly one cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bypass_merge_en <= 1'b0;
      long_burst_allow <= 1'b0;
      long_burst_break <= 1'b1;
      write_watermark <= 4'h0;
      read_issue_one <= 1'b0;
      write_issue_one <= 1'b0;
      upstream_read_issue_one <= 1'b0;
      upstream_write_issue_one <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_next;
      end
      bypass_merge_en <= bm_eff;
      long_burst_allow <= lb_eff;
      long_burst_break <= !lb_eff;
      write_watermark <= wm_eff;
      read_issue_one <= il_q[`BIT_READ_OVERRIDE];
      write_issue_one <= il_q[`BIT_WRITE_OVERRIDE];
      upstream_read_issue_one <= sw_eff[`BIT_READ_OVERRIDE];
      upstream_write_issue_one <= sw_eff[`BIT_WRITE_OVERRIDE];
    end
  end

endmodule

// ---- sim/bridge_cfg_sva.sv ----
`timescale 1ns/1ps
module bridge_cfg_chk (
  input logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input logic [31:0] paddr, pwdata, prdata,
  input logic bypass_merge_en, long_burst_allow, long_burst_break,
  input logic [3:0] write_watermark,
  input logic read_issue_one, write_issue_one, upstream_read_issue_one, upstream_write_issue_one
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A field lands at the write edge and its output one edge later, hence the extra delay.
  sequence wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  chk_lb_inverse: assert property (long_burst_break == !long_burst_allow)
    else $error("break flag wrong");
  chk_lb_set: assert property (wr('h2c) |=> ##1 long_burst_allow == $past(pwdata[0],2))
    else $error("long burst flag wrong");
  chk_bm_set: assert property (wr('h24) |=> ##1 bypass_merge_en == $past(pwdata[0],2))
    else $error("bypass flag wrong");
  chk_wm_set: assert property (wr('h40) |=> ##1 write_watermark == $past(pwdata[3:0],2))
    else $error("watermark wrong");
  chk_iss_set: assert property (wr('h108) |=> ##1
    {write_issue_one, read_issue_one} == $past(pwdata[1:0],2)) else $error("issue flags wrong");
  chk_up_set: assert property (wr('h8) |=> ##1
    {upstream_write_issue_one, upstream_read_issue_one} == $past(pwdata[1:0],2))
    else $error("switch flags wrong");
  chk_gap_read: assert property (psel && penable && pready && !pwrite && paddr == 'h28
    |-> prdata == 0) else $error("gap read not zero");
  chk_gap_write: assert property (wr('h1024) |=> ##1 $stable(bypass_merge_en))
    else $error("gap write had effect");
  chk_no_err: assert property (!pslverr) else $error("error response");
endmodule
bind bridge_block_config_regs bridge_cfg_chk u_chk (.*);

// ---- sim/burst_sink.sv ----
`timescale 1ns/1ps
module burst_sink (
  input logic long_burst_allow,
  output logic [8:0] max_beats
);
  // The far side only takes long bursts while the bridge allows them.
  assign max_beats = long_burst_allow ? 9'h100 : 9'h010;
endmodule

// ---- sim/bridge_block_config_regs_test.sv ----
`timescale 1ns/1ps
module bridge_block_config_regs_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic pready, pslverr, bypass_merge_en, long_burst_allow, long_burst_break;
  logic [3:0] write_watermark;
  logic read_issue_one, write_issue_one, upstream_read_issue_one, upstream_write_issue_one;
  logic [8:0] max_beats;
  int miscompares = 0, checks = 0;
  logic [31:0] m[int], k[int];
  int al[8] = '{'h8, 'h24, 'h2c, 'h40, 'h108, 'h28, 'h10c, 'h1024};
  bridge_block_config_regs dut (.*);
  burst_sink far (.long_burst_allow(long_burst_allow), .max_beats(max_beats));
  initial forever #12.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task ck(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // An idle edge follows each transfer so no signal is driven twice in one step.
  task apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin n++; @(posedge pclk); end
    if (n == 50) begin
      miscompares++;
      tally_and_finish;
    end
    r = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task rst;
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    m[8] = 0; m['h24] = 0; m['h2c] = 0; m['h40] = 4; m['h108] = 0;
    repeat (2) @(posedge pclk);
  endtask
  task outs;
    ck({max_beats, upstream_write_issue_one, upstream_read_issue_one, bypass_merge_en,
        long_burst_allow, long_burst_break, write_watermark, write_issue_one, read_issue_one},
       {m['h2c][0] ? 9'h100 : 9'h010, m[8][1:0], m['h24][0], m['h2c][0], ~m['h2c][0],
        m['h40][3:0], m['h108][1:0]});
  endtask
  task tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int a, d;
    a = $urandom(99979);
    k[8] = 3; k['h24] = 1; k['h2c] = 1; k['h40] = 'hf; k['h108] = 3;
    rst;
    outs;
    foreach (al[i]) begin
      apb(0, al[i], 0, r);
      ck(r, m.exists(al[i]) ? m[al[i]] : 0);
    end
    repeat (40) begin
      a = al[$urandom_range(7)];
      d = $urandom;
      apb(1, a, d, r);
      if (k.exists(a)) m[a] = d & k[a];
      apb(0, a, 0, r);
      ck(r, m.exists(a) ? m[a] : 0);
      outs;
    end
    rst;
    outs;
    tally_and_finish;
  end
  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
endmodule
